// ===== include/ahr_pkg.sv
// Purpose: shared constants and types of the axis home-return sequencer
// Assumes: 10 MHz system clock, incremental encoder position count from outside
// Notes:   method and reference codes are the values the caller puts on the select inputs
`default_nettype none
package ahr_pkg;
  ////////////////////////////////////////////////////////////////////////////////
  // widths and reset values
  localparam int              POS_W       = 32;
  localparam logic [POS_W-1:0] HOME_COORD = 32'h0000_0000;  // coordinate given to home
  localparam logic [POS_W-1:0] OFFSET_RST = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // home return methods
  localparam logic [3:0] M_NEAR_FRONT  = 4'h0;  // near switch rise, then reference edge
  localparam logic [3:0] M_NEAR_ONLY   = 4'h1;  // near switch rise only
  localparam logic [3:0] M_NEAR_REAR   = 4'h2;  // near switch fall, then reference edge
  localparam logic [3:0] M_LIMIT_REV   = 4'h3;  // far limit rise, reverse, reference edge
  localparam logic [3:0] M_LIMIT_ONLY  = 4'h4;  // limit in homing direction only
  localparam logic [3:0] M_INDEX_ONLY  = 4'h5;  // reference edge only
  localparam logic [3:0] M_CONTACT_ONE = 4'h6;  // stopper torque held for a time
  localparam logic [3:0] M_CONTACT_TWO = 4'h7;  // stopper, reverse, reference edge
  localparam logic [3:0] M_DATA_SET    = 4'h8;  // present position becomes home

  ////////////////////////////////////////////////////////////////////////////////
  // final reference edge source
  localparam logic [1:0] REF_INDEX       = 2'h0;
  localparam logic [1:0] REF_LATCH_TWO   = 2'h1;  // second_latch_variant
  localparam logic [1:0] REF_LATCH_THREE = 2'h2;  // third_latch_variant

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int CONTACT_TIME_US = 100;  // torque must persist this long
  localparam int CONTACT_CYCLES  = CONTACT_TIME_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W           = 11;
  localparam logic [CNT_W-1:0] CNT_RST  = 11'h000;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONTACT_CYCLES - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_SEEK, ST_WAIT_REF} ahr_state_e;
endpackage
`default_nettype wire

// ===== design/ahr_home_seq.sv
// Purpose: home-return sequencer for one servo axis with an incremental encoder
// Assumes: all inputs synchronous to clk; motion profile generator obeys moveEn/moveDirFwd
// Notes:   home is recorded as a position offset; axisPos reads zero at home
//
// Contract
// RQ1: at home completion the axis coordinate becomes zero.
// RQ2: near-front mode: after near switch rises, stop on first index rise.
// RQ3: near-only mode: stop on near switch rise, that position is home.
// RQ4: near-rear mode: after near switch falls, stop on first index rise.
// RQ5: limit-reversal: opposite limit rises, reverse, stop on first index rise.
// RQ6: limit-only: stop on rise of the limit in homing direction.
// RQ7: index-only: move toward homing direction, stop on first index rise.
// RQ8: contact one: home once torque over threshold persists the set time.
// RQ9: contact two: after stopper halt, reverse and stop on index rise.
// RQ10: data-setting: no motion, present position taken as home.
// RQ11: variants two and three use latch input two or three instead of index.
// RQ12: index already high at start is not a reference edge.
// RQ13: methods are selectable only with an incremental encoder.
// RQ14: done flag rises on completion, held until any next operation starts.
// RQ15: edges sampled on clk; position captured the cycle the edge is seen.
`default_nettype none
module ahr_home_seq (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     startReq,
  input  wire logic [3:0]               methodSel,
  input  wire logic [1:0]               refSel,
  input  wire logic                     homeDirFwd,
  input  wire logic                     encIncremental,
  input  wire logic                     otherOpStart,
  input  wire logic                     nearHomeSwitch,
  input  wire logic                     limitFwd,
  input  wire logic                     limitRev,
  input  wire logic                     encIndex,
  input  wire logic                     latchInputTwo,
  input  wire logic                     latchInputThree,
  input  wire logic                     torqueAbove,
  input  wire logic [ahr_pkg::POS_W-1:0] positionIn,
  output logic                          moveEn,
  output logic                          moveDirFwd,
  output logic                          busy,
  output logic                          homeSet,
  output logic                          opDone,
  output logic [ahr_pkg::POS_W-1:0]     homeOffset,
  output logic [ahr_pkg::POS_W-1:0]     axisPos
);
  ahr_pkg::ahr_state_e              state_reg, state_next;
  logic                             dir_reg, dir_next;
  logic                             prevNear_reg, prevLimF_reg, prevLimR_reg, prevRef_reg;
  logic [ahr_pkg::CNT_W-1:0]        contactCnt_reg, contactCnt_next;
  logic [ahr_pkg::POS_W-1:0]        offset_reg, axisPos_reg, axisPos_next;
  logic                             done_reg, homeSet_reg;
  logic                             refLevel, refRise, nearRise, nearFall;
  logic                             limFRise, limRRise, limHomeRise, limOppRise;
  logic                             contactHit, startOk, seekHit, capture, goRef, reverse;

  //////////////////////////////////////////////////////////////////////////////
  // edge detection on clk; registered previous levels avoid a false edge at start
  assign refLevel = (refSel == ahr_pkg::REF_LATCH_TWO)   ? latchInputTwo :   // RQ11
                    (refSel == ahr_pkg::REF_LATCH_THREE) ? latchInputThree :
                                                           encIndex;
  assign refRise  = refLevel & ~prevRef_reg;          // RQ12 RQ15
  assign nearRise = nearHomeSwitch & ~prevNear_reg;   // RQ15
  assign nearFall = ~nearHomeSwitch & prevNear_reg;
  assign limFRise = limitFwd & ~prevLimF_reg;
  assign limRRise = limitRev & ~prevLimR_reg;
  assign limHomeRise = homeDirFwd ? limFRise : limRRise;
  assign limOppRise  = homeDirFwd ? limRRise : limFRise;
  assign contactHit  = torqueAbove && (contactCnt_reg == ahr_pkg::CNT_LAST);  // RQ8

  // a start is taken only from idle and only with an incremental encoder
  assign startOk = startReq && encIncremental && (state_reg == ahr_pkg::ST_IDLE);  // RQ13

  //////////////////////////////////////////////////////////////////////////////
  // first-stage event per method while seeking
  assign seekHit = (methodSel == ahr_pkg::M_NEAR_ONLY)   ? nearRise :     // RQ3
                   (methodSel == ahr_pkg::M_LIMIT_ONLY)  ? limHomeRise :  // RQ6
                   (methodSel == ahr_pkg::M_CONTACT_ONE) ? contactHit :   // RQ8
                   1'b0;
  assign goRef   = (methodSel == ahr_pkg::M_NEAR_FRONT)  ? nearRise :     // RQ2
                   (methodSel == ahr_pkg::M_NEAR_REAR)   ? nearFall :     // RQ4
                   (methodSel == ahr_pkg::M_LIMIT_REV)   ? limOppRise :   // RQ5
                   (methodSel == ahr_pkg::M_CONTACT_TWO) ? contactHit :   // RQ9
                   1'b0;
  // these two methods first run away from home, then turn round
  assign reverse = (methodSel == ahr_pkg::M_LIMIT_REV) ||
                   (methodSel == ahr_pkg::M_CONTACT_TWO);

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_next = state_reg;
    dir_next   = dir_reg;
    capture    = 1'b0;
    case (state_reg)
      ahr_pkg::ST_IDLE: begin
        if (startOk) begin
          dir_next = reverse ? ~homeDirFwd : homeDirFwd;
          if (methodSel == ahr_pkg::M_DATA_SET) begin
            capture = 1'b1;                                   // RQ10
          end else if (methodSel == ahr_pkg::M_INDEX_ONLY) begin
            state_next = ahr_pkg::ST_WAIT_REF;                // RQ7
          end else begin
            state_next = ahr_pkg::ST_SEEK;                    // RQ12
          end
        end
      end
      ahr_pkg::ST_SEEK: begin
        if (seekHit) begin
          capture    = 1'b1;
          state_next = ahr_pkg::ST_IDLE;
        end else if (goRef) begin
          dir_next   = homeDirFwd;                            // RQ5 RQ9
          state_next = ahr_pkg::ST_WAIT_REF;
        end
      end
      ahr_pkg::ST_WAIT_REF: begin
        if (refRise) begin
          capture    = 1'b1;                                  // RQ2 RQ4 RQ7
          state_next = ahr_pkg::ST_IDLE;
        end
      end
      default: state_next = ahr_pkg::ST_IDLE;
    endcase
  end

  // torque timer only runs in ST_SEEK, whatever the method; any dip restarts it
  assign contactCnt_next = (state_reg != ahr_pkg::ST_SEEK || !torqueAbove || contactHit) ?
                           ahr_pkg::CNT_RST : contactCnt_reg + 1'b1;
  // coordinate reads zero the cycle after capture, with homeSet, and relative to home after that
  assign axisPos_next = capture ? ahr_pkg::HOME_COORD : positionIn - offset_reg;  // RQ1

  //////////////////////////////////////////////////////////////////////////////
  // state and edge registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg      <= ahr_pkg::ST_IDLE;
      dir_reg        <= 1'b0;
      contactCnt_reg <= ahr_pkg::CNT_RST;
      prevNear_reg   <= 1'b0;
      prevLimF_reg   <= 1'b0;
      prevLimR_reg   <= 1'b0;
      prevRef_reg    <= 1'b0;
    end else begin
      state_reg      <= state_next;
      dir_reg        <= dir_next;
      contactCnt_reg <= contactCnt_next;
      prevNear_reg   <= nearHomeSwitch;
      prevLimF_reg   <= limitFwd;
      prevLimR_reg   <= limitRev;
      prevRef_reg    <= refLevel;
    end
  end

  // home capture and done flag; a completion beats a same-cycle clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      offset_reg  <= ahr_pkg::OFFSET_RST;
      axisPos_reg <= ahr_pkg::HOME_COORD;
      done_reg    <= 1'b0;
      homeSet_reg <= 1'b0;
    end else begin
      if (capture) offset_reg <= positionIn;                  // RQ15
      axisPos_reg <= axisPos_next;
      homeSet_reg <= capture;
      if (capture) done_reg <= 1'b1;                          // RQ14
      else if (startOk || otherOpStart) done_reg <= 1'b0;     // RQ14
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign busy       = (state_reg != ahr_pkg::ST_IDLE);
  assign moveEn     = busy;             // motion stops the cycle after capture
  assign moveDirFwd = dir_reg;
  assign homeSet    = homeSet_reg;
  assign opDone     = done_reg;
  assign homeOffset = offset_reg;
  assign axisPos    = axisPos_reg;

  // assertion helper: run of consecutive torque samples, saturating so it never wraps
  logic [ahr_pkg::CNT_W-1:0] torqueRun_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) torqueRun_reg <= ahr_pkg::CNT_RST;
    else if (!torqueAbove) torqueRun_reg <= ahr_pkg::CNT_RST;
    else if (torqueRun_reg != 11'h7ff) torqueRun_reg <= torqueRun_reg + 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_zero_at_home: assert property (homeSet |-> axisPos == ahr_pkg::HOME_COORD) // RQ1
    else $error("axis coordinate not zero at home");
  chk_offset_capture: assert property (capture |=> homeOffset == $past(positionIn)) // RQ15
    else $error("home offset is not the position of the capture cycle");
  chk_ref_stop: assert property (state_reg == ahr_pkg::ST_WAIT_REF && refRise // RQ2
    |=> !moveEn && homeSet)
    else $error("motion not stopped on reference edge");
  chk_near_only: assert property (state_reg == ahr_pkg::ST_SEEK && nearRise && // RQ3
    methodSel == ahr_pkg::M_NEAR_ONLY |=> homeSet && !busy)
    else $error("near-only mode missed the near switch rise");
  chk_rear_edge: assert property (state_reg == ahr_pkg::ST_SEEK && nearFall && // RQ4
    methodSel == ahr_pkg::M_NEAR_REAR |=> state_reg == ahr_pkg::ST_WAIT_REF)
    else $error("rear edge did not arm the reference search");
  chk_limit_reverse: assert property (state_reg == ahr_pkg::ST_SEEK && limOppRise && // RQ5
    methodSel == ahr_pkg::M_LIMIT_REV |=> moveDirFwd == homeDirFwd && moveEn)
    else $error("limit reversal did not turn the motor");
  chk_limit_only: assert property (state_reg == ahr_pkg::ST_SEEK && limHomeRise && // RQ6
    methodSel == ahr_pkg::M_LIMIT_ONLY |=> homeSet)
    else $error("limit-only mode missed the limit rise");
  chk_contact_time: assert property (homeSet && $past(state_reg) == ahr_pkg::ST_SEEK && // RQ8
    methodSel == ahr_pkg::M_CONTACT_ONE |-> torqueRun_reg > ahr_pkg::CNT_LAST)
    else $error("contact home taken without sustained torque");
  chk_data_set: assert property (startOk && methodSel == ahr_pkg::M_DATA_SET // RQ10
    |=> !moveEn && homeSet)
    else $error("data setting moved or failed to set home");
  chk_no_level_ref: assert property (startOk && methodSel == ahr_pkg::M_INDEX_ONLY && // RQ12
    refLevel ##1 refLevel |=> !homeSet)
    else $error("index level at start taken as reference");
  chk_need_incr: assert property (startReq && !encIncremental && !busy |=> !busy) // RQ13
    else $error("home return started without incremental encoder");
  chk_done_hold: assert property (opDone && !startOk && !otherOpStart |=> opDone) // RQ14
    else $error("done flag dropped without a new operation");

  cov_near_front: cover property (startOk && methodSel == ahr_pkg::M_NEAR_FRONT
    ##[1:1000] homeSet);
  cov_contact_one: cover property (startOk && methodSel == ahr_pkg::M_CONTACT_ONE
    ##[1:1000] homeSet);
  cov_latch_three: cover property (refSel == ahr_pkg::REF_LATCH_THREE && capture);
  cov_data_set: cover property (startOk && methodSel == ahr_pkg::M_DATA_SET);
endmodule
`default_nettype wire

// ===== test/ahr_axis_model.sv
// Purpose: behavioural axis, encoder and field switches facing the home sequencer
// Assumes: one count per clock while commanded to move, none while pushing into a stopper; updates on the falling edge
// Notes:   index two counts wide every 16 counts, latch inputs single counts at 4 and 8
`default_nettype none
module ahr_axis_model #(
  parameter int NEAR_LO = 40,
  parameter int NEAR_HI = 60,
  parameter int LIM_HI  = 100,
  parameter int LIM_LO  = -100,
  parameter int STOP_HI = 120,
  parameter int STOP_LO = -120
) (
  input  wire logic        clk,
  input  wire logic        loadEn,
  input  wire logic [31:0] loadVal,
  input  wire logic        moveEn,
  input  wire logic        moveDirFwd,
  output logic [31:0]      positionIn,
  output logic             nearHomeSwitch,
  output logic             limitFwd,
  output logic             limitRev,
  output logic             encIndex,
  output logic             latchInputTwo,
  output logic             latchInputThree,
  output logic             torqueAbove
);
  timeunit 1ns;
  timeprecision 1ns;
  logic signed [31:0] pos_reg;
  logic               pushing;
  ////////////////////////////////////////
  // stopper clamps motion; pushing into it shows as torque over threshold
  assign pushing = moveEn && (moveDirFwd ? pos_reg >= STOP_HI : pos_reg <= STOP_LO);
  assign torqueAbove = pushing;
  assign nearHomeSwitch = pos_reg >= NEAR_LO && pos_reg <= NEAR_HI;
  assign limitFwd = pos_reg >= LIM_HI;
  assign limitRev = pos_reg <= LIM_LO;
  assign encIndex = pos_reg[3:1] == 3'h0;  // wide enough to still stand a cycle after start
  assign latchInputTwo = pos_reg[3:0] == 4'h4;
  assign latchInputThree = pos_reg[3:0] == 4'h8;
  assign positionIn = pos_reg;
  ////////////////////////////////////////
  // load places the axis between runs, so every run starts from a known count
  always_ff @(negedge clk) begin
    if (loadEn) pos_reg <= loadVal;
    else if (moveEn && !pushing) pos_reg <= moveDirFwd ? pos_reg + 1 : pos_reg - 1;
  end
endmodule
`default_nettype wire

// ===== test/ahr_home_seq_tb.sv
// Purpose: self-checking bench for the axis home-return sequencer
// Assumes: axis model drives the switches; bench inputs change on the falling edge
// Notes:   each run loads a start count and checks where home lands
`default_nettype none
module ahr_home_seq_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_b, startReq, homeDirFwd, encIncremental, otherOpStart, loadEn;
  logic [3:0]  methodSel;
  logic [1:0]  refSel;
  logic [31:0] loadVal;
  wire logic   nearHomeSwitch, limitFwd, limitRev, encIndex, latchInputTwo, latchInputThree;
  wire logic   torqueAbove, moveEn, moveDirFwd, busy, homeSet, opDone;
  wire logic [31:0] positionIn, homeOffset, axisPos;
  int          n_mismatch = 0, compares = 0, cycles = 0, torqueCnt = 0;

  ahr_home_seq ahr_home_seq_i (.clk, .rst_b, .startReq, .methodSel, .refSel, .homeDirFwd,
    .encIncremental, .otherOpStart, .nearHomeSwitch, .limitFwd, .limitRev, .encIndex,
    .latchInputTwo, .latchInputThree, .torqueAbove, .positionIn, .moveEn, .moveDirFwd,
    .busy, .homeSet, .opDone, .homeOffset, .axisPos);
  ahr_axis_model ahr_axis_model_i (.clk, .loadEn, .loadVal, .moveEn, .moveDirFwd,
    .positionIn, .nearHomeSwitch, .limitFwd, .limitRev, .encIndex, .latchInputTwo,
    .latchInputThree, .torqueAbove);
  ////////////////////////////////////////
  // free-running 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // cycle ceiling cuts a hang short; torque count feeds the contact check
  always @(posedge clk) begin
    cycles++;
    if (busy === 1'b1 && torqueAbove === 1'b1) torqueCnt++;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one home return: place axis, pulse start, wait bounded for the home pulse
  task automatic run(input logic [3:0] m, input logic [1:0] r, input logic d, input logic d0,
                     input logic [31:0] p0, input logic [31:0] exp, input string nm);
    int n;
    @(negedge clk);
    loadEn <= 1'b1;
    loadVal <= p0;
    methodSel <= m;
    refSel <= r;
    homeDirFwd <= d;
    @(negedge clk);
    loadEn <= 1'b0;
    startReq <= 1'b1;
    @(negedge clk);
    startReq <= 1'b0;
    torqueCnt = 0;
    if (m != ahr_pkg::M_DATA_SET) begin
      chk({busy, opDone}, 2'b10, "busy after start");
      chk(moveDirFwd, d0, "first direction");
    end
    n = 0;
    while (homeSet !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk(axisPos, ahr_pkg::HOME_COORD, "coordinate at home");
    chk(homeOffset, exp, "home position");
    chk({busy, moveEn, opDone}, 3'b001, "flags at home");
    $display("test %s done", nm);
  endtask
  ////////////////////////////////////////
  task automatic t_near();
    run(ahr_pkg::M_NEAR_FRONT, 2'h0, 1'b1, 1'b1, 32'h0, 32'h30, "near front");
    run(ahr_pkg::M_NEAR_ONLY, 2'h0, 1'b1, 1'b1, 32'h0, 32'h28, "near only");
    run(ahr_pkg::M_NEAR_REAR, 2'h0, 1'b1, 1'b1, 32'h0, 32'h40, "near rear");
  endtask
  task automatic t_limit();
    run(ahr_pkg::M_LIMIT_REV, 2'h0, 1'b1, 1'b0, 32'h0, 32'hffff_ffa0, "limit rev");
    run(ahr_pkg::M_LIMIT_ONLY, 2'h0, 1'b1, 1'b1, 32'h0, 32'h64, "limit only");
  endtask
  // index level high at start must not count; latch variants replace the index
  task automatic t_index();
    run(ahr_pkg::M_INDEX_ONLY, 2'h0, 1'b0, 1'b0, 32'h21, 32'h11, "index");
    run(ahr_pkg::M_INDEX_ONLY, ahr_pkg::REF_LATCH_TWO, 1'b1, 1'b1, 32'h0, 32'h4, "l2");
    run(ahr_pkg::M_INDEX_ONLY, ahr_pkg::REF_LATCH_THREE, 1'b1, 1'b1, 32'h0, 32'h8, "l3");
  endtask
  task automatic t_contact();
    run(ahr_pkg::M_CONTACT_ONE, 2'h0, 1'b1, 1'b1, 32'h0, 32'h78, "contact one");
    chk(32'(torqueCnt), 32'(ahr_pkg::CONTACT_CYCLES), "torque cycles");
    run(ahr_pkg::M_CONTACT_TWO, 2'h0, 1'b1, 1'b0, 32'h0, 32'hffff_ff90, "contact two");
  endtask
  // start refused without incremental encoder; another operation clears done
  task automatic t_data_done();
    run(ahr_pkg::M_DATA_SET, 2'h0, 1'b1, 1'b1, 32'h4d, 32'h4d, "data set");
    chk(positionIn, 32'h4d, "no motion");
    @(negedge clk);
    methodSel <= ahr_pkg::M_NEAR_FRONT;  // a wrongly taken start would then show busy
    encIncremental <= 1'b0;
    startReq <= 1'b1;
    repeat (3) @(negedge clk);
    chk({busy, opDone}, 2'b01, "start refused");
    startReq <= 1'b0;
    encIncremental <= 1'b1;
    otherOpStart <= 1'b1;
    @(negedge clk);
    otherOpStart <= 1'b0;
    @(negedge clk);
    chk(opDone, 1'b0, "done cleared");
    $display("test done flag done");
  endtask
  ////////////////////////////////////////
  // reset with the axis parked at zero, then the scenarios in turn
  initial begin
    rst_b = 1'b0;
    startReq = 1'b0;
    otherOpStart = 1'b0;
    encIncremental = 1'b1;
    homeDirFwd = 1'b1;
    methodSel = 4'h0;
    refSel = 2'h0;
    loadEn = 1'b1;
    loadVal = 32'h0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_b <= 1'b1;
    loadEn <= 1'b0;
    t_near();
    t_limit();
    t_index();
    t_contact();
    t_data_done();
    report_and_stop();
  end
endmodule
`default_nettype wire
